// File: src/cfec_defs.svh
`ifndef CFEC_DEFS_SVH
`define CFEC_DEFS_SVH

// Byte addresses on the register bus
`define CFEC_ADDR_FLAGS_A   12'h000
`define CFEC_ADDR_FLAGS_B   12'h004
`define CFEC_ADDR_ENABLE_A  12'h008
`define CFEC_ADDR_ENABLE_B  12'h00C
`define CFEC_ADDR_STATUS    12'h010
`define CFEC_ADDR_CONTROL   12'h014
`define CFEC_ADDR_FIFO_CFG  12'h018

// Write mode selector
`define CFEC_MODE_BIT       7

// Flags A positions
`define CFEC_A_TX_DONE      0
`define CFEC_A_RX_DONE      1
`define CFEC_A_CMD_DONE     2
`define CFEC_A_FIFO_HIGH    3
`define CFEC_A_FIFO_LOW     4
`define CFEC_A_RX_ERROR     5
`define CFEC_A_CARD_DETECT  6

// Flags B positions
`define CFEC_B_TIMER_BASE   0
`define CFEC_B_FRAME_START  4
`define CFEC_B_ANY_SOURCE   6

// Status and control positions
`define CFEC_STAT_IRQ       0
`define CFEC_STAT_FIFO_HIGH 1
`define CFEC_STAT_FIFO_LOW  2
`define CFEC_CTRL_PIN_EN    0
`define CFEC_CTRL_PIN_INV   1

// Reset values
`define CFEC_RST_FLAGS      8'h00
`define CFEC_RST_ENABLE     8'h00
`define CFEC_RST_CONTROL    8'h01
`define CFEC_RST_THRESHOLD  9'h008

`endif

// File: src/cfec_pkg.sv
package cfec_pkg;

	// Event pulses from the source units
	typedef struct packed {
		logic [3:0] timer_underflow;
		logic       tx_to_eof;
		logic       rx_end;
		logic       cmd_idle;
		logic       rx_sof;
		logic       card_detect;
	} cfec_events_t;

	// FIFO monitor inputs
	typedef struct packed {
		logic [9:0] fill_count;
		logic [9:0] depth;
		logic       error_any;
	} cfec_monitor_t;

	typedef enum logic [1:0] {
		CFEC_BUS_IDLE,
		CFEC_BUS_WRITE,
		CFEC_BUS_READ
	} cfec_bus_phase_t;

endpackage

// File: src/cfec_event_controller.sv
//
// Contract
// - Two 8-bit flag registers, each with its own 8-bit enable register.
// - Write bit 7 selects whether bits 0..6 written one are set or cleared.
// - Software may raise or clear any flag by writing, except the any-source flag in register B.
// - Each source is individually enabled by its enable bit.
// - Enabled event sets status summary bit; pin asserted if pin output active.
// - Four timer flags in register B set on matching timer underflow.
// - Transmit-done flag set when transmitter moves from data to end-of-frame.
// - Receive-done flag set when receiver detects end of received data.
// - Command-finished flag set when command completes and returns to idle.
// - One threshold defines high level from top and low level from bottom.
// - FIFO high flag set when high status rises, fill reaches top level.
// - FIFO low flag set when low status rises, fill reaches bottom level.
// - Error flag set when any bit of the error register becomes one.
// - Card-detect flag set when low-power card detection finds a card.
// - Frame-start flag set on start of frame or subcarrier detection.
// - Any-source flag in register B set while any enabled source is set.
//
`timescale 1ns/1ps
`include "cfec_defs.svh"

module cfec_event_controller #(
	parameter int THRESH_W = 9
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   srst,
	// AHB-Lite slave
	input  wire logic                   hsel,
	input  wire logic [11:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic      [31:0]            hrdata,
	output logic                        hreadyout,
	output logic                        hresp,
	// Source units, same clock
	input  wire cfec_pkg::cfec_events_t  events,
	input  wire cfec_pkg::cfec_monitor_t monitor,
	// Interrupt request toward host
	output logic                        irq_pin
);

	logic [7:0]          event_flags_a_reg;
	logic [7:0]          event_flags_b_reg;
	logic [7:0]          event_enable_a_reg;
	logic [7:0]          event_enable_b_reg;
	logic [7:0]          control_reg;
	logic [THRESH_W-1:0] threshold_reg;
	logic                wr_pend_reg;
	logic [11:0]         wr_addr_reg;
	logic [31:0]         rdata_next;
	logic                fifo_high_status;
	logic                fifo_low_status;
	logic                fifo_high_dly_reg;
	logic                fifo_low_dly_reg;
	logic                error_dly_reg;
	logic [7:0]          hw_set_a;
	logic [7:0]          hw_set_b;
	logic                any_enabled;
	logic                wr_a;
	logic                wr_b;
	logic [6:0]          wmask;
	logic                wmode;
	logic [10:0]         thr_ext;
	logic [10:0]         top_level;
	wire logic [7:0]     event_flags_a_next;
	wire logic [7:0]     event_flags_b_next;
	logic [7:0]          event_enable_a_next;
	logic [7:0]          event_enable_b_next;
	logic [7:0]          control_next;
	logic [THRESH_W-1:0] threshold_next;
	logic                wr_en_a;
	logic                wr_en_b;
	logic                wr_ctrl;
	logic                wr_cfg;
	logic                rd_take;
	logic                irq_next;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Write data phase decode
	assign wmode = hwdata[`CFEC_MODE_BIT];
	assign wmask = hwdata[6:0];
	assign wr_a  = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_FLAGS_A);
	assign wr_b  = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_FLAGS_B);

	// Threshold levels from top and bottom
	assign thr_ext   = 11'(threshold_reg);
	assign top_level = (11'(monitor.depth) > thr_ext) ? (11'(monitor.depth) - thr_ext) : 11'h000;
	assign fifo_high_status = (11'(monitor.fill_count) >= top_level);
	assign fifo_low_status  = (11'(monitor.fill_count) <= thr_ext);

	// Hardware set terms, edge of level statuses
	always_comb
	begin
		hw_set_a = 8'h00;
		hw_set_b = 8'h00;
		hw_set_a[`CFEC_A_TX_DONE]     = events.tx_to_eof;
		hw_set_a[`CFEC_A_RX_DONE]     = events.rx_end;
		hw_set_a[`CFEC_A_CMD_DONE]    = events.cmd_idle;
		hw_set_a[`CFEC_A_FIFO_HIGH]   = fifo_high_status && !fifo_high_dly_reg;
		hw_set_a[`CFEC_A_FIFO_LOW]    = fifo_low_status && !fifo_low_dly_reg;
		hw_set_a[`CFEC_A_RX_ERROR]    = monitor.error_any && !error_dly_reg;
		hw_set_a[`CFEC_A_CARD_DETECT] = events.card_detect;
		hw_set_b[`CFEC_B_TIMER_BASE +: 4] = events.timer_underflow;
		hw_set_b[`CFEC_B_FRAME_START] = events.rx_sof;
	end

	// High level history for edge detection
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			fifo_high_dly_reg <= 1'b0;
		else
			fifo_high_dly_reg <= fifo_high_status;
	end

	// Low level history for edge detection
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			fifo_low_dly_reg <= 1'b0;
		else
			fifo_low_dly_reg <= fifo_low_status;
	end

	// Error level history for edge detection
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			error_dly_reg <= 1'b0;
		else
			error_dly_reg <= monitor.error_any;
	end

	// Any enabled source, excluding the summary bit itself
	assign any_enabled = |(event_flags_a_reg[6:0] & event_enable_a_reg[6:0])
		| |(event_flags_b_reg[5:0] & event_enable_b_reg[5:0]);

	// Bus address phase capture
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 12'h000;
		end
		else if (hready)
		begin
			wr_pend_reg <= hsel && htrans[1] && hwrite;
			wr_addr_reg <= haddr;
		end
	end

	// Per-bit flag next values, hardware set priority
	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : g_flag
			assign event_flags_a_next[gi] = (hw_set_a[gi] || (wr_a && wmask[gi] && wmode)) ? 1'b1
				: (wr_a && wmask[gi]) ? 1'b0 : event_flags_a_reg[gi];
			if (gi == `CFEC_B_ANY_SOURCE)
			begin : g_any
				assign event_flags_b_next[gi] = any_enabled;
			end
			else
			begin : g_src
				assign event_flags_b_next[gi] = (hw_set_b[gi] || (wr_b && wmask[gi] && wmode)) ? 1'b1
					: (wr_b && wmask[gi]) ? 1'b0 : event_flags_b_reg[gi];
			end
		end
	endgenerate

	// Bit 7 of flag registers is the write mode bit, reads zero
	assign event_flags_a_next[7] = 1'b0;
	assign event_flags_b_next[7] = 1'b0;

	// Flag register A
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			event_flags_a_reg <= `CFEC_RST_FLAGS;
		else
			event_flags_a_reg <= event_flags_a_next;
	end

	// Flag register B
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			event_flags_b_reg <= `CFEC_RST_FLAGS;
		else
			event_flags_b_reg <= event_flags_b_next;
	end

	// Data phase write strobes
	assign wr_en_a = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_ENABLE_A);
	assign wr_en_b = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_ENABLE_B);
	assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_CONTROL);
	assign wr_cfg  = wr_pend_reg && (wr_addr_reg == `CFEC_ADDR_FIFO_CFG);

	// Enable A next value, set or clear by mode bit
	always_comb
	begin
		event_enable_a_next = event_enable_a_reg;
		if (wr_en_a)
		begin
			if (wmode)
				event_enable_a_next[6:0] = event_enable_a_reg[6:0] | wmask;
			else
				event_enable_a_next[6:0] = event_enable_a_reg[6:0] & ~wmask;
		end
	end

	// Enable B next value, set or clear by mode bit
	always_comb
	begin
		event_enable_b_next = event_enable_b_reg;
		if (wr_en_b)
		begin
			if (wmode)
				event_enable_b_next[6:0] = event_enable_b_reg[6:0] | wmask;
			else
				event_enable_b_next[6:0] = event_enable_b_reg[6:0] & ~wmask;
		end
	end

	// Control and threshold next values
	assign control_next   = wr_ctrl ? hwdata[7:0] : control_reg;
	assign threshold_next = wr_cfg ? hwdata[THRESH_W-1:0] : threshold_reg;

	// Enable register A
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			event_enable_a_reg <= `CFEC_RST_ENABLE;
		else
			event_enable_a_reg <= event_enable_a_next;
	end

	// Enable register B
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			event_enable_b_reg <= `CFEC_RST_ENABLE;
		else
			event_enable_b_reg <= event_enable_b_next;
	end

	// Control register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			control_reg <= `CFEC_RST_CONTROL;
		else
			control_reg <= control_next;
	end

	// Threshold register
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			threshold_reg <= THRESH_W'(`CFEC_RST_THRESHOLD);
		else
			threshold_reg <= threshold_next;
	end

	// Read mux
	always_comb
	begin
		rdata_next = 32'h0000_0000;
		case (haddr)
			`CFEC_ADDR_FLAGS_A:  rdata_next[7:0] = event_flags_a_reg;
			`CFEC_ADDR_FLAGS_B:  rdata_next[7:0] = event_flags_b_reg;
			`CFEC_ADDR_ENABLE_A: rdata_next[7:0] = event_enable_a_reg;
			`CFEC_ADDR_ENABLE_B: rdata_next[7:0] = event_enable_b_reg;
			`CFEC_ADDR_STATUS:
			begin
				rdata_next[`CFEC_STAT_IRQ]       = event_flags_b_reg[`CFEC_B_ANY_SOURCE];
				rdata_next[`CFEC_STAT_FIFO_HIGH] = fifo_high_status;
				rdata_next[`CFEC_STAT_FIFO_LOW]  = fifo_low_status;
			end
			`CFEC_ADDR_CONTROL:  rdata_next[7:0] = control_reg;
			`CFEC_ADDR_FIFO_CFG: rdata_next[THRESH_W-1:0] = threshold_reg;
			default:             rdata_next = 32'h0000_0000;
		endcase
	end

	// Read taken in the address phase
	assign rd_take = hready && hsel && htrans[1] && !hwrite;

	// Read data register, holds until the next read
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			hrdata <= 32'h0000_0000;
		else if (rd_take)
			hrdata <= rdata_next;
	end

	// Interrupt pin, gated and optionally inverted
	assign irq_next = (event_flags_b_reg[`CFEC_B_ANY_SOURCE] && control_reg[`CFEC_CTRL_PIN_EN])
		^ control_reg[`CFEC_CTRL_PIN_INV];

	always_ff @(posedge sys_clk)
	begin
		if (srst)
			irq_pin <= 1'b0;
		else
			irq_pin <= irq_next;
	end

endmodule // cfec_event_controller

// File: tb/cfec_checker_assertions.sv
`timescale 1ns/1ps
module cfec_checker (
	// Clock, reset, single-bit bus signals and request pin
	input wire logic sys_clk, srst, hsel, hwrite, hready, hreadyout, hresp, irq_pin,
	// Bus vectors
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [31:0] hrdata,
	// Sources
	input wire cfec_pkg::cfec_events_t events,
	input wire cfec_pkg::cfec_monitor_t monitor
);
	logic rd;
	logic wr;
	logic [4:0] ch_q;
	logic [4:0] wr_q;
	cfec_pkg::cfec_monitor_t mon_q;
	assign rd = hsel && htrans[1] && hready && !hwrite;
	assign wr = hsel && htrans[1] && hready && hwrite;
	// Recent causes of a change on the request pin
	always_ff @(posedge sys_clk)
	begin
		mon_q <= monitor;
		wr_q <= {wr_q[3:0], wr};
		ch_q <= {ch_q[3:0], wr || events != '0 || monitor != mon_q};
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	chk_ready_high: assert property (hreadyout) else $error("hreadyout low");
	chk_resp_okay: assert property (!hresp) else $error("hresp not okay");
	chk_unmapped_zero: assert property (rd && haddr > 12'h018 |=> hrdata == '0)
		else $error("unmapped read not zero");
	chk_read_width: assert property (rd |=> hrdata[31:9] == '0)
		else $error("read wider than register");
	chk_mode_bit_zero: assert property (rd && haddr < 12'h010 |=> hrdata[31:7] == '0)
		else $error("mode bit read back");
	chk_data_hold: assert property (!$past(rd) |-> $stable(hrdata)) else $error("hrdata moved");
	chk_irq_cause: assert property ($changed(irq_pin) |-> |ch_q[4:1])
		else $error("irq moved without cause");
	chk_irq_fall: assert property ($fell(irq_pin) |-> |wr_q[3:2])
		else $error("irq fell without write");
endmodule // cfec_checker
bind cfec_event_controller cfec_checker u_chk (.sys_clk, .srst, .hsel, .hwrite, .hready, .hreadyout,
	.hresp, .irq_pin, .haddr, .htrans, .hrdata, .events, .monitor);

// File: tb/cfec_src_model.sv
`timescale 1ns/1ps
module cfec_src_model (
	// Stimulus
	input wire logic sys_clk,
	input wire logic [8:0] req,
	input wire logic [9:0] fill,
	input wire logic err,
	// Toward the controller
	output cfec_pkg::cfec_events_t events,
	output cfec_pkg::cfec_monitor_t monitor
);
	logic [8:0] req_q;
	always_ff @(posedge sys_clk)
		req_q <= req;
	// One-cycle pulse per newly raised bit
	assign events = cfec_pkg::cfec_events_t'(req & ~req_q);
	assign monitor = '{fill_count: fill, depth: 10'h200, error_any: err};
endmodule // cfec_src_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("mismatch %0t %h %h", $time, a, e); end end
module tb_top;
	logic sys_clk = 1'h0, srst = 1'h1, hsel = 1'h0, hwrite = 1'h0, err = 1'h0, hreadyout, hresp, irq_pin;
	logic [11:0] haddr = 12'h000;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0, hrdata;
	logic [8:0] req = 9'h000;
	logic [9:0] fill = 10'h064;
	logic [7:0] ea [9] = '{8'h40, 8'h00, 8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] eb [9] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h04, 8'h08};
	int fails = 0, checks = 0;
	cfec_pkg::cfec_events_t events;
	cfec_pkg::cfec_monitor_t monitor;
	always #50 sys_clk = ~sys_clk;
	cfec_src_model u_src (.sys_clk, .req, .fill, .err, .events, .monitor);
	cfec_event_controller DUT (.sys_clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .events, .monitor, .irq_pin);
	task automatic end_sim();
		$display("counts checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cyc();
		@(posedge sys_clk);
		for (int n = 0; hreadyout !== 1'h1; n++)
		begin
			fails += int'(n > 20);
			if (n > 20)
				end_sim();
			@(posedge sys_clk);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
		hsel <= 1'h1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		cyc();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		cyc();
		if (!w)
			`CHK(hrdata, e)
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'h1, a, {24'h0, d}, 32'h0);
	endtask
	task automatic rd(input logic [11:0] a, input logic [8:0] e);
		xfer(1'h0, a, 32'h0, {23'h0, e});
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'h0;
		for (int i = 0; i < 7; i++)
			rd(12'(i * 4), i == 5 ? 9'h001 : i == 6 ? 9'h008 : 9'h000);
		$display("test reset values done");
		wr(12'h000, 8'h85);
		rd(12'h000, 9'h005);
		wr(12'h000, 8'h01);
		wr(12'h000, 8'h00);
		rd(12'h000, 9'h004);
		wr(12'h008, 8'hFF);
		rd(12'h008, 9'h07F);
		idle(5);
		`CHK(irq_pin, 1'h1)
		rd(12'h010, 9'h001);
		rd(12'h004, 9'h040);
		wr(12'h014, 8'h00);
		idle(5);
		`CHK(irq_pin, 1'h0)
		wr(12'h014, 8'h01);
		wr(12'h008, 8'h04);
		idle(5);
		`CHK(irq_pin, 1'h0)
		rd(12'h004, 9'h000);
		wr(12'h000, 8'h7F);
		$display("test software access done");
		wr(12'h008, 8'hFF);
		wr(12'h00C, 8'hFF);
		for (int i = 0; i < 9; i++)
		begin
			req <= 9'(1 << i);
			idle(4);
			rd(12'h000, {1'h0, ea[i]});
			rd(12'h004, {1'h0, eb[i] | 8'h40});
			wr(12'h000, 8'h7F);
			wr(12'h004, 8'h7F);
		end
		fork
			wr(12'h000, 8'h01);
			begin
				@(posedge sys_clk);
				req <= 9'h010;
			end
		join
		rd(12'h000, 9'h001);
		wr(12'h000, 8'h7F);
		$display("test hardware sources done");
		fill <= 10'h1F7;
		idle(4);
		rd(12'h000, 9'h000);
		fill <= 10'h1F8;
		idle(4);
		rd(12'h010, 9'h003);
		rd(12'h000, 9'h008);
		fill <= 10'h009;
		idle(4);
		rd(12'h000, 9'h008);
		fill <= 10'h008;
		idle(4);
		rd(12'h010, 9'h005);
		rd(12'h000, 9'h018);
		err <= 1'h1;
		idle(4);
		rd(12'h000, 9'h038);
		wr(12'h020, 8'hFF);
		rd(12'h020, 9'h000);
		$display("test levels and unmapped done");
		end_sim();
	end
endmodule // tb_top
